/* testbench/tcc_assertions.sv */
// checker on the ports of the timer capture/compare unit, bound to its top
`timescale 1ns/10ps
module tcc_assertions
	import tcc_pkg::*;
(
	input wire logic              I_REF_CLK,      // clock
	input wire logic              I_RST_N,        // reset, active low
	input wire logic              I_CE,           // clock enable
	input wire logic              I_PSEL,         // apb select
	input wire logic              I_PENABLE,      // apb enable
	input wire logic              I_PWRITE,       // apb direction
	input wire logic [ADDR_W-1:0] I_PADDR,        // apb address
	input wire logic [31:0]       I_PWDATA,       // apb write data
	input wire logic [2:0]        I_CAPTURE_PINS, // capture pins
	input wire logic              I_CPU_IRQ_MASK, // global mask
	input wire logic [31:0]       O_PRDATA,       // apb read data
	input wire logic              O_PREADY,       // apb ready
	input wire logic              O_PSLVERR,      // apb error
	input wire logic [4:0]        O_TIMER_PINS,   // compare pins
	input wire logic [4:0]        O_CMP_IRQ,      // compare requests
	input wire logic [2:0]        O_CAP_IRQ       // capture requests
);
	logic [2:0] stb_q;
	wire logic  rd = O_PREADY && !I_PWRITE;
	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RST_N);
	// the pin filter lags a few cycles, so level reads are judged only on quiet pins
	always_ff @(posedge I_REF_CLK) begin
		if (!I_RST_N || I_CAPTURE_PINS != $past(I_CAPTURE_PINS)) stb_q <= 3'h0;
		else if (stb_q != 3'h7) stb_q <= stb_q + 3'h1;
	end
	a_ready_one: assert property (O_PREADY |=> !O_PREADY)
		else $error("ready held over one cycle");
	a_ready_wait: assert property (I_CE && I_PSEL && !I_PENABLE ##1 I_CE && I_PSEL && I_PENABLE
		|=> O_PREADY) else $error("ready late");
	a_ready_cause: assert property (O_PREADY |-> I_PSEL && I_PENABLE && $past(I_PSEL && I_PENABLE))
		else $error("ready without access");
	a_err_ready: assert property (O_PSLVERR |-> O_PREADY) else $error("error without ready");
	a_err_unmapped: assert property (O_PREADY && (I_PADDR[1:0] != 2'h0 || I_PADDR > OFF_GPIO)
		|-> O_PSLVERR) else $error("unmapped not refused");
	a_err_mapped: assert property (O_PREADY && I_PADDR[1:0] == 2'h0 && I_PADDR <= OFF_GPIO
		|-> !O_PSLVERR) else $error("mapped refused");
	a_rdata_idle: assert property (!O_PREADY |-> O_PRDATA == 32'h0) else $error("stray read data");
	a_irq_cpu_mask: assert property ($past(I_CPU_IRQ_MASK && I_CE) |-> O_CAP_IRQ == 3'h0)
		else $error("capture request while masked");
	a_level_read: assert property (rd && I_PADDR == OFF_PIN_LVL && stb_q == 3'h7
		|-> O_PRDATA == {29'h0, I_CAPTURE_PINS}) else $error("pin level read wrong");
	a_force_read: assert property (rd && I_PADDR == OFF_FORCE |-> O_PRDATA == 32'h0)
		else $error("force reads nonzero");
	c_cmp_irq: cover property (O_CMP_IRQ != 5'h0);
	c_cap_irq: cover property (O_CAP_IRQ != 3'h0);
	c_slverr: cover property (O_PSLVERR);
endmodule : tcc_assertions

bind tcc_top tcc_assertions tcc_assertions_inst (.I_REF_CLK, .I_RST_N, .I_CE, .I_PSEL,
	.I_PENABLE, .I_PWRITE, .I_PADDR, .I_PWDATA, .I_CAPTURE_PINS, .I_CPU_IRQ_MASK, .O_PRDATA,
	.O_PREADY, .O_PSLVERR, .O_TIMER_PINS, .O_CMP_IRQ, .O_CAP_IRQ);

/* testbench/tcc_event_src.sv */
// outside event source driving the capture pins
`timescale 1ns/10ps
module tcc_event_src (
	input  wire logic       i_clk,  // bench clock
	output logic      [2:0] o_pins  // levels on the capture inputs
);
	initial o_pins = 3'h0;
	// levels move just after an edge and then hold, like a slow external signal
	task automatic drive(input logic [2:0] v);
		@(posedge i_clk);
		o_pins <= v;
	endtask : drive
endmodule : tcc_event_src

/* testbench/tcc_top_tb.sv */
// self-checking bench for the timer capture/compare unit
`timescale 1ns/10ps
module tcc_top_tb;
	import tcc_pkg::*;
	logic        clk, rst_n, psel, penable, pwrite, mask, pready, pslverr, err, ce;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, c0;
	logic [2:0]  cap_pins, cap_irq;
	logic [4:0]  tpins, cmp_irq;
	int          miscompares, checks, cycles;
	tcc_top tcc_top_inst (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_PSEL(psel),
		.I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.I_CAPTURE_PINS(cap_pins), .I_CPU_IRQ_MASK(mask), .O_PRDATA(prdata), .O_PREADY(pready),
		.O_PSLVERR(pslverr), .O_TIMER_PINS(tpins), .O_CMP_IRQ(cmp_irq), .O_CAP_IRQ(cap_irq));
	tcc_event_src tcc_event_src_inst (.i_clk(clk), .o_pins(cap_pins));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic tally_and_finish();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : tally_and_finish
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			miscompares++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask : chk
	// one apb transfer, entered just after a rising edge; an idle cycle follows
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : bus
	function automatic logic [7:0] ca(input int n);
		return OFF_CMP_BASE + CMP_STRIDE * 8'(n);
	endfunction : ca
	task automatic setcmp(input int n, input logic [15:0] v);
		bus(1'b1, ca(n), {24'h0, v[15:8]});
		bus(1'b1, ca(n) + CMP_LO_DELTA, {24'h0, v[7:0]});
	endtask : setcmp
	task automatic wait_flag(input logic [7:0] m);
		do bus(1'b0, OFF_FLAGS, 32'h0); while ((rd[7:0] & m) !== m);
	endtask : wait_flag
	// outputs as {capture irq, compare irq, pins}, judged mid-cycle
	task automatic look(input logic [12:0] e);
		@(negedge clk);
		chk({19'h0, cap_irq, cmp_irq, tpins}, {19'h0, e});
		@(posedge clk);
	endtask : look
	initial begin
		{psel, penable, pwrite, mask, rst_n} = '0;
		ce = 1'b1;
		paddr = '0;
		pwdata = '0;
		{miscompares, checks, cycles} = '0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int n = 0; n < NUM_CMP; n++) begin
			bus(1'b0, ca(n), 32'h0);
			chk(rd, 32'hff);
			bus(1'b0, ca(n) + CMP_LO_DELTA, 32'h0);
			chk(rd, 32'hff);
		end
		bus(1'b0, 8'h5c, 32'h0);
		chk({31'h0, err}, 32'h1);
		bus(1'b0, OFF_FORCE, 32'h0);
		$display("test reset done");
		bus(1'b1, OFF_GPIO, 32'h1f);
		bus(1'b1, OFF_ACTION, 32'h39);
		look({3'h0, 5'h00, 5'h11});
		bus(1'b0, OFF_COUNTER, 32'h0);
		c0 = rd + 32'd100;
		for (int n = 1; n < NUM_CMP; n++) setcmp(n, c0[15:0]);
		wait_flag(8'h1e);
		chk(rd, 32'h1e);
		look({3'h0, 5'h00, 5'h1b});
		bus(1'b1, OFF_IRQ_EN, 32'h02);
		look({3'h0, 5'h02, 5'h1b});
		bus(1'b1, OFF_FLAGS, 32'h02);
		bus(1'b0, OFF_FLAGS, 32'h0);
		chk(rd, 32'h1c);
		$display("test compare actions done");
		bus(1'b1, OFF_GPIO, 32'h00);
		bus(1'b1, OFF_MMASK, 32'h03);
		bus(1'b1, OFF_MDATA, 32'h03);
		bus(1'b0, OFF_COUNTER, 32'h0);
		c0 = rd + 32'd60;
		setcmp(0, c0[15:0]);
		setcmp(1, c0[15:0]);
		wait_flag(8'h03);
		look({3'h0, 5'h02, 5'h0b});
		$display("test master channel done");
		bus(1'b1, OFF_FLAGS, 32'h1f);
		bus(1'b1, OFF_MDATA, 32'h00);
		bus(1'b1, OFF_ACTION, 32'h3d);
		bus(1'b1, OFF_FORCE, 32'h05);
		look({3'h0, 5'h00, 5'h0c});
		bus(1'b0, OFF_FLAGS, 32'h0);
		chk(rd, 32'h0);
		$display("test force done");
		bus(1'b1, OFF_EDGE, 32'h39);
		bus(1'b1, OFF_IRQ_EN, 32'h20);
		mask <= 1'b1;
		bus(1'b0, OFF_COUNTER, 32'h0);
		c0 = rd;
		ce <= 1'b0;
		repeat (10) @(posedge clk);
		ce <= 1'b1;
		bus(1'b0, OFF_COUNTER, 32'h0);
		chk(rd - c0, 32'h4);
		c0 = rd;
		tcc_event_src_inst.drive(3'h7);
		repeat (8) @(posedge clk);
		bus(1'b0, OFF_FLAGS, 32'h0);
		chk(rd, 32'ha0);
		look({3'h0, 5'h00, 5'h0c});
		bus(1'b0, OFF_PIN_LVL, 32'h0);
		chk(rd, 32'h7);
		bus(1'b0, OFF_CAP_BASE, 32'h0);
		chk({31'h0, (rd[15:0] - c0[15:0]) < 16'd20}, 32'h1);
		c0 = rd;
		bus(1'b0, OFF_CAP_BASE + 8'h08, 32'h0);
		chk(rd, c0);
		mask <= 1'b0;
		@(posedge clk);
		look({3'h1, 5'h00, 5'h0c});
		bus(1'b1, OFF_FLAGS, 32'he0);
		bus(1'b0, OFF_FLAGS, 32'h0);
		chk(rd, 32'h0);
		tcc_event_src_inst.drive(3'h0);
		repeat (8) @(posedge clk);
		bus(1'b0, OFF_FLAGS, 32'h0);
		chk(rd, 32'hc0);
		$display("test capture done");
		tally_and_finish();
	end
endmodule : tcc_top_tb

/* verilog/tcc_cmp_chan.sv */
// one output-compare channel: 16-bit value register written a byte at a time, write inhibit and comparator
`timescale 1ns/10ps
module tcc_cmp_chan
	import tcc_pkg::*;
(
	input  wire logic        i_clk,     // bus clock
	input  wire logic        i_rst_n,   // synchronous reset, active low
	input  wire logic        i_ce,      // clock enable, freezes state when low
	input  wire logic        i_wr_hi,   // write strobe for the high byte
	input  wire logic        i_wr_lo,   // write strobe for the low byte
	input  wire logic [7:0]  i_wdata,   // byte to write
	input  wire logic [15:0] i_cnt,     // shared free-running counter
	output logic      [15:0] o_value,   // stored compare value
	output logic             o_match    // counter equals value this cycle
);

	tcc_cmp_state_t q;
	tcc_cmp_state_t d;

	always_comb begin
		d = q;
		if (i_wr_hi) begin
			d.value[15:8] = i_wdata;
		end
		if (i_wr_lo) begin
			d.value[7:0] = i_wdata;
		end
		// one quiet cycle after a high write, so the half-updated value cannot hit in its first cycle
		d.inh = i_wr_hi;
		if (!i_ce) begin
			d = q;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			q <= CMP_STATE_RST;
		end else begin
			q <= d;
		end
	end

	assign o_value = q.value;
	// equality every counter step, so every wrap gives a fresh hit
	assign o_match = (q.value == i_cnt) && !q.inh;

endmodule : tcc_cmp_chan

/* verilog/tcc_pkg.sv */
// package with the register map, codes and state layouts of the timer capture/compare unit
package tcc_pkg;

	localparam int            CNT_W        = 16;
	localparam int            NUM_CMP      = 5;
	localparam int            NUM_CAP      = 3;
	localparam int            ADDR_W       = 8;
	localparam logic [15:0]   CMP_RESET    = 16'hffff;
	localparam logic [15:0]   CNT_STEP     = 16'h0001;

	// compare channel n: high byte at base + n*stride, low byte four bytes above it
	localparam logic [7:0]    OFF_CMP_BASE = 8'h00;
	localparam logic [7:0]    CMP_STRIDE   = 8'h08;
	localparam logic [7:0]    CMP_LO_DELTA = 8'h04;
	localparam logic [7:0]    OFF_ACTION   = 8'h28;
	localparam logic [7:0]    OFF_MMASK    = 8'h2c;
	localparam logic [7:0]    OFF_MDATA    = 8'h30;
	localparam logic [7:0]    OFF_FORCE    = 8'h34;
	localparam logic [7:0]    OFF_EDGE     = 8'h38;
	localparam logic [7:0]    OFF_IRQ_EN   = 8'h3c;
	localparam logic [7:0]    OFF_FLAGS    = 8'h40;
	localparam logic [7:0]    OFF_CAP_BASE = 8'h44;
	localparam logic [7:0]    OFF_COUNTER  = 8'h50;
	localparam logic [7:0]    OFF_PIN_LVL  = 8'h54;
	localparam logic [7:0]    OFF_GPIO     = 8'h58;

	// flag and enable layout: compare channels low, capture channels above
	localparam int            FLG_CMP_LSB  = 0;
	localparam int            FLG_CAP_LSB  = 5;

	localparam logic [1:0]    EDGE_OFF     = 2'h0;
	localparam logic [1:0]    EDGE_RISE    = 2'h1;
	localparam logic [1:0]    EDGE_FALL    = 2'h2;
	localparam logic [1:0]    EDGE_ANY     = 2'h3;

	localparam logic [1:0]    ACT_NONE     = 2'h0;
	localparam logic [1:0]    ACT_TOGGLE   = 2'h1;
	localparam logic [1:0]    ACT_CLEAR    = 2'h2;
	localparam logic [1:0]    ACT_SET      = 2'h3;

	typedef struct packed {
		logic              sel;
		logic              en;
		logic              wr;
		logic [ADDR_W-1:0] addr;
		logic [31:0]       wdata;
	} tcc_apb_req_t;

	typedef struct packed {
		logic [15:0] value;
		logic        inh;
	} tcc_cmp_state_t;

	localparam tcc_cmp_state_t CMP_STATE_RST = '{value: CMP_RESET, inh: 1'b0};

	typedef struct packed {
		logic [15:0]                 cnt;
		logic [3:0][1:0]             act;
		logic [4:0]                  mmask;
		logic [4:0]                  mdata;
		logic [4:0]                  gpio;
		logic [2:0][1:0]             edge_sel;
		logic [7:0]                  ien;
		logic [7:0]                  flg;
		logic [2:0][15:0]            cap;
		logic [2:0]                  sync1;
		logic [2:0]                  sync2;
		logic [2:0]                  sync3;
		logic [2:0]                  lvl;
		logic [4:0]                  tpin;
		logic [4:0]                  pins;
		logic [4:0]                  irq_cmp;
		logic [2:0]                  irq_cap;
		logic                        ready;
		logic                        slverr;
		logic [31:0]                 rdata;
	} tcc_state_t;

	localparam tcc_state_t TCC_STATE_RST = '0;

endpackage : tcc_pkg

/* verilog/tcc_top.sv */
// timer capture/compare unit: shared counter, three captures, five compares, APB registers
// Function
// - selected capture edge latches counter value
// - capture pin levels always readable
// - capture pins act as own interrupt sources
// - per-channel capture edge selection
// - per-channel capture interrupt enable bits
// - readable capture pending flags, clearable anytime
// - global CPU mask blocks capture interrupts
// - five compare registers, own comparators
// - compare against counter every increment
// - match sets flag, interrupt, pin action
// - separate enable and line per compare
// - master channel drives any pin combination
// - two-bit pin action for channels two-five
// - channels two-five own one pin each
// - master mask selects affected pins
// - master match drives pins from data
// - master channel wins same-cycle pin conflicts
// - pins serve as GPIO or timer outputs
// - timer-owned pins ignore GPIO writes
// - force applies pin action without match
// - compare registers accessed as two bytes
// - reset loads compare registers all ones
// - high-byte write inhibits compare one cycle
// - compare flag cleared by writing one
// - enabled set flag requests interrupt
// - action on every match, not first
`timescale 1ns/10ps
module tcc_top
	import tcc_pkg::*;
(
	input  wire logic              I_REF_CLK,      // bus clock, 100 MHz
	input  wire logic              I_RST_N,        // synchronous reset, active low
	input  wire logic              I_CE,           // clock enable, freezes all state when low
	input  wire logic              I_PSEL,         // APB select
	input  wire logic              I_PENABLE,      // APB enable
	input  wire logic              I_PWRITE,       // APB direction, high for write
	input  wire logic [ADDR_W-1:0] I_PADDR,        // APB byte address
	input  wire logic [31:0]       I_PWDATA,       // APB write data
	input  wire logic [2:0]        I_CAPTURE_PINS, // asynchronous capture pins
	input  wire logic              I_CPU_IRQ_MASK, // processor global interrupt mask bit
	output logic      [31:0]       O_PRDATA,       // APB read data
	output logic                   O_PREADY,       // APB ready
	output logic                   O_PSLVERR,      // APB error, unmapped address
	output logic      [4:0]        O_TIMER_PINS,   // compare output pins
	output logic      [4:0]        O_CMP_IRQ,      // one request per compare channel
	output logic      [2:0]        O_CAP_IRQ       // one request per capture channel
);

	tcc_state_t   q;
	tcc_state_t   d;
	tcc_apb_req_t req;

	logic [4:0]       wr_hi;
	logic [4:0]       wr_lo;
	logic [4:0][15:0] cmp_val;
	logic [4:0]       match;
	logic             access;
	logic             complete;
	logic [4:0]       sel_hi;
	logic [4:0]       sel_lo;
	logic [2:0]       sel_cap;

	assign req = '{
		sel:   I_PSEL,
		en:    I_PENABLE,
		wr:    I_PWRITE,
		addr:  I_PADDR,
		wdata: I_PWDATA
	};

	// access covers both access cycles; complete is the one edge at which a
	// write lands, so every register update hangs off it
	always_comb begin
		access   = req.sel && req.en;
		complete = access && q.ready;
	end

	// address decode shared by the write strobes and the read mux
	always_comb begin
		for (int k = 0; k < NUM_CMP; k++) begin
			sel_hi[k] = (req.addr == OFF_CMP_BASE + 8'(k) * CMP_STRIDE);
			sel_lo[k] = (req.addr == OFF_CMP_BASE + 8'(k) * CMP_STRIDE + CMP_LO_DELTA);
		end
		for (int i = 0; i < NUM_CAP; i++) begin
			sel_cap[i] = (req.addr == OFF_CAP_BASE + 8'(i) * CMP_LO_DELTA);
		end
	end

	// byte strobes for the compare registers, taken only at the completing edge
	always_comb begin
		for (int k = 0; k < NUM_CMP; k++) begin
			wr_hi[k] = complete && req.wr && I_CE && sel_hi[k];
			wr_lo[k] = complete && req.wr && I_CE && sel_lo[k];
		end
	end

	// each compare channel keeps its own value, inhibit and comparator
	genvar g;
	generate
		for (g = 0; g < NUM_CMP; g++) begin : g_cmp
			tcc_cmp_chan u_chan (
				.i_clk   (I_REF_CLK),
				.i_rst_n (I_RST_N),
				.i_ce    (I_CE),
				.i_wr_hi (wr_hi[g]),
				.i_wr_lo (wr_lo[g]),
				.i_wdata (req.wdata[7:0]),
				.i_cnt   (q.cnt),
				.o_value (cmp_val[g]),
				.o_match (match[g])
			);
		end
	endgenerate

	logic              wr_done;
	logic [4:0]        frc;
	logic [4:0]        hit;
	logic [4:0]        tp;
	logic [4:0]        use_tmr;
	logic [2:0]        new_lvl;
	logic [2:0]        rise;
	logic [2:0]        fall;
	logic [2:0]        cap_ev;
	logic [2:0]        want_rise;
	logic [2:0]        want_fall;
	logic [31:0]       rd;
	logic              rd_err;

	always_comb begin
		d       = q;
		wr_done = complete && req.wr;
		frc     = 5'h00;
		tp      = q.tpin;
		use_tmr = 5'h00;
		new_lvl = q.lvl;
		rise    = 3'h0;
		fall    = 3'h0;
		cap_ev  = 3'h0;
		want_rise = 3'h0;
		want_fall = 3'h0;
		rd      = 32'h0000_0000;
		rd_err  = 1'b0;

		// shared counter, plain 16-bit wrap
		d.cnt = q.cnt + CNT_STEP;

		// three-stage pin synchroniser; the level moves once stages two and three agree
		d.sync1 = I_CAPTURE_PINS;
		d.sync2 = q.sync1;
		d.sync3 = q.sync2;
		for (int i = 0; i < NUM_CAP; i++) begin
			if (q.sync2[i] == q.sync3[i]) begin
				new_lvl[i] = q.sync3[i];
			end
			rise[i] = new_lvl[i] & ~q.lvl[i];
			fall[i] = ~new_lvl[i] & q.lvl[i];
			want_rise[i] = (q.edge_sel[i] == EDGE_RISE) || (q.edge_sel[i] == EDGE_ANY);
			want_fall[i] = (q.edge_sel[i] == EDGE_FALL) || (q.edge_sel[i] == EDGE_ANY);
			cap_ev[i]    = (rise[i] && want_rise[i]) || (fall[i] && want_fall[i]);
			if (cap_ev[i]) begin
				d.cap[i] = q.cnt;
			end
		end
		d.lvl = new_lvl;

		// register writes at the completing edge
		if (wr_done) begin
			unique case (req.addr)
				OFF_ACTION: begin
					d.act = req.wdata[7:0];
				end
				OFF_MMASK: begin
					d.mmask = req.wdata[4:0];
				end
				OFF_MDATA: begin
					d.mdata = req.wdata[4:0];
				end
				OFF_FORCE: begin
					frc = req.wdata[4:0];
				end
				OFF_EDGE: begin
					d.edge_sel = req.wdata[5:0];
				end
				OFF_IRQ_EN: begin
					d.ien = req.wdata[7:0];
				end
				OFF_FLAGS: begin
					d.flg = q.flg & ~req.wdata[7:0];
				end
				OFF_GPIO: begin
					d.gpio = req.wdata[4:0];
				end
				default: begin
					// read-only and unmapped words keep their state
				end
			endcase
		end

		// hardware set is applied after the clear, so a same-cycle event survives
		d.flg[FLG_CMP_LSB +: NUM_CMP] = d.flg[FLG_CMP_LSB +: NUM_CMP] | match;
		d.flg[FLG_CAP_LSB +: NUM_CAP] = d.flg[FLG_CAP_LSB +: NUM_CAP] | cap_ev;

		// a forced channel acts on its pins but raises no flag
		hit = match | frc;

		// channels two to five each own one pin
		for (int k = 1; k < NUM_CMP; k++) begin
			if (hit[k]) begin
				unique case (q.act[k-1])
					ACT_NONE: begin
						tp[k] = q.tpin[k];
					end
					ACT_TOGGLE: begin
						tp[k] = ~q.tpin[k];
					end
					ACT_CLEAR: begin
						tp[k] = 1'b0;
					end
					ACT_SET: begin
						tp[k] = 1'b1;
					end
				endcase
			end
			use_tmr[k] = (q.act[k-1] != ACT_NONE);
		end

		// master channel overrides whatever the single-pin channel decided
		for (int p = 0; p < NUM_CMP; p++) begin
			if (hit[0] && q.mmask[p]) begin
				tp[p] = q.mdata[p];
			end
		end
		// a pin belongs to the timer while any channel may act on it
		use_tmr = use_tmr | q.mmask;
		d.tpin  = tp;

		// timer-owned pins show timer state; the GPIO value is held but not seen
		for (int p = 0; p < NUM_CMP; p++) begin
			d.pins[p] = use_tmr[p] ? tp[p] : d.gpio[p];
		end

		// interrupt lines follow flags and enables; capture lines obey the CPU mask
		d.irq_cmp = d.flg[FLG_CMP_LSB +: NUM_CMP] & d.ien[FLG_CMP_LSB +: NUM_CMP];
		d.irq_cap = d.flg[FLG_CAP_LSB +: NUM_CAP] & d.ien[FLG_CAP_LSB +: NUM_CAP];
		if (I_CPU_IRQ_MASK) begin
			d.irq_cap = 3'h0;
		end

		// read decode
		unique case (req.addr)
			OFF_ACTION: begin
				rd[7:0] = q.act;
			end
			OFF_MMASK: begin
				rd[4:0] = q.mmask;
			end
			OFF_MDATA: begin
				rd[4:0] = q.mdata;
			end
			OFF_FORCE: begin
				rd = 32'h0000_0000;
			end
			OFF_EDGE: begin
				rd[5:0] = q.edge_sel;
			end
			OFF_IRQ_EN: begin
				rd[7:0] = q.ien;
			end
			OFF_FLAGS: begin
				rd[7:0] = q.flg;
			end
			OFF_COUNTER: begin
				rd[15:0] = q.cnt;
			end
			OFF_PIN_LVL: begin
				rd[2:0] = q.lvl;
			end
			OFF_GPIO: begin
				rd[4:0] = q.gpio;
			end
			default: begin
				rd_err = 1'b1;
			end
		endcase
		for (int k = 0; k < NUM_CMP; k++) begin
			if (sel_hi[k]) begin
				rd     = {24'h00_0000, cmp_val[k][15:8]};
				rd_err = 1'b0;
			end
			if (sel_lo[k]) begin
				rd     = {24'h00_0000, cmp_val[k][7:0]};
				rd_err = 1'b0;
			end
		end
		for (int i = 0; i < NUM_CAP; i++) begin
			if (sel_cap[i]) begin
				rd[15:0] = q.cap[i];
				rd_err   = 1'b0;
			end
		end

		// one wait state: ready rises in the access phase and drops after completion
		if (access && !q.ready) begin
			d.ready  = 1'b1;
			d.slverr = rd_err;
			d.rdata  = 32'h0000_0000;
			// write data is never echoed and a refused read returns zero
			if (!req.wr && !rd_err) begin
				d.rdata = rd;
			end
		end else begin
			d.ready  = 1'b0;
			d.slverr = 1'b0;
			d.rdata  = 32'h0000_0000;
		end

		if (!I_CE) begin
			d = q;
		end
	end

	// reset ignores the clock enable so a frozen unit still starts clean
	always_ff @(posedge I_REF_CLK) begin
		if (!I_RST_N) begin
			q <= TCC_STATE_RST;
		end else begin
			q <= d;
		end
	end

	assign O_PRDATA     = q.rdata;
	assign O_PREADY     = q.ready;
	assign O_PSLVERR    = q.slverr;
	assign O_TIMER_PINS = q.pins;
	assign O_CMP_IRQ    = q.irq_cmp;
	assign O_CAP_IRQ    = q.irq_cap;

endmodule : tcc_top
